// ===== inc/sccc_map.vh
`ifndef SCCC_MAP_VH
`define SCCC_MAP_VH
// register offsets
`define SCCC_OFS_DIV_HI 8'h01
`define SCCC_OFS_DIV_LO 8'h02
`define SCCC_OFS_SYNC 8'h10
`define SCCC_OFS_CLAMP 8'h11
`define SCCC_OFS_PRE 8'h12
`define SCCC_OFS_POST 8'h13
`define SCCC_OFS_OUTP 8'h14
// reset values
`define SCCC_RST_DIV_HI 8'h69
`define SCCC_RST_DIV_LO 4'hd
`define SCCC_RST_SYNC 8'h40
`define SCCC_RST_CLAMP 8'h0a
`define SCCC_RST_PRE 8'h00
`define SCCC_RST_POST 8'h00
`define SCCC_RST_OUTP 8'he2
// field positions, sync register
`define SCCC_HPOL_OVR 7
`define SCCC_HPOL_IN 6
`define SCCC_HPOL_OUT 5
`define SCCC_HSRC_OVR 4
`define SCCC_HSRC_SEL 3
`define SCCC_VPOL_OUT 2
`define SCCC_VSRC_OVR 1
`define SCCC_VSRC_SEL 0
// field positions, clamp/coast register
`define SCCC_CLAMP_OFF 7
`define SCCC_CLAMP_R 6
`define SCCC_CLAMP_G 5
`define SCCC_CLAMP_B 4
`define SCCC_COAST_EN 3
`define SCCC_CPOL_OVR 2
`define SCCC_CPOL_IN 1
// field positions, output/power register
`define SCCC_DRIVE_HI 7
`define SCCC_DRIVE_LO 6
`define SCCC_BW_HIGH 5
`define SCCC_CLK_INV 4
`define SCCC_PDO_HIZ 3
`define SCCC_HDCP_ADR 2
`define SCCC_RUN 1
`endif

// ===== hdl/sccc_wr_port.v
`timescale 1ns/100ps
`default_nettype none
// register storage cell: byte with write strobe and reset value
module sccc_wr_port #(
  parameter [7:0] RST_VAL = 8'h00
) (
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire [7:0] wr_data,
  output reg [7:0] q_r
);
  // synchronous reset, last write wins
  always @(posedge sys_clk) begin
    if (rst) begin
      q_r <= RST_VAL;
    end else if (wr_en) begin
      q_r <= wr_data;
    end
  end
endmodule // sccc_wr_port
`default_nettype wire

// ===== hdl/sccc_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "sccc_map.vh"
module sccc_regs (
  input wire sys_clk,
  input wire rst,
  // byte-level access from the two-wire serial port engine
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg reg_rvalid_r,
  // status from the sync and interface blocks
  input wire hsync_pol_detected,
  input wire coast_pol_detected,
  input wire hsync_both_active,
  input wire digital_mode,
  // control outputs
  output reg [11:0] line_clock_divide_ratio_r,
  output reg hsync_in_high_r,
  output reg hsync_out_low_r,
  output reg hsync_from_green_channel_sync_r,
  output reg vsync_out_noninv_r,
  output reg vsync_src_force_r,
  output reg vsync_from_separator_r,
  output reg clamp_enable_r,
  output reg [2:0] clamp_midscale_r,
  output reg coast_enable_r,
  output reg coast_in_high_r,
  output reg [7:0] pre_coast_lines_r,
  output reg [7:0] post_coast_lines_r,
  output reg [1:0] drive_strength_r,
  output reg bandwidth_high_r,
  output reg data_clock_invert_r,
  output reg pixel_data_outputs_hiz_r,
  output reg hdcp_addr_bit_r,
  output reg power_down_r
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  ////////////////////////////////////////////////////////////////////////////

  // one-hot write strobe for a given offset
  function wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // stored register bytes
  wire [7:0] div_hi_q;
  wire [7:0] div_lo_q;
  wire [7:0] sync_source_polarity_control;
  wire [7:0] clamp_coast_control;
  wire [7:0] pre_coast_lines;
  wire [7:0] post_coast_lines;
  wire [7:0] output_power_control;
  wire div_lo_wr;
  wire div_hi_wr;
  wire sync_wr;
  wire clamp_wr;
  wire pre_wr;
  wire post_wr;
  wire outp_wr;

  // one strobe per mapped byte; unmapped offsets raise none, so writes there are lost
  assign div_lo_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_DIV_LO);
  assign div_hi_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_DIV_HI);
  assign sync_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_SYNC);
  assign clamp_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_CLAMP);
  assign pre_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_PRE);
  assign post_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_POST);
  assign outp_wr = wr_hit(reg_wr, reg_addr, `SCCC_OFS_OUTP);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  ////////////////////////////////////////////////////////////////////////////

  // divider bytes; high byte is staged only, never applied by itself
  sccc_wr_port #(.RST_VAL(`SCCC_RST_DIV_HI)) u_div_hi (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(div_hi_wr),
    .wr_data(reg_wdata),
    .q_r(div_hi_q)
  );
  // low nibble lives in bits 7..4, lower bits read zero
  sccc_wr_port #(.RST_VAL({`SCCC_RST_DIV_LO, 4'h0})) u_div_lo (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(div_lo_wr),
    .wr_data({reg_wdata[7:4], 4'h0}),
    .q_r(div_lo_q)
  );
  sccc_wr_port #(.RST_VAL(`SCCC_RST_SYNC)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(sync_wr),
    .wr_data(reg_wdata),
    .q_r(sync_source_polarity_control)
  );
  // bit 0 of the clamp/coast byte is unused and reads zero
  sccc_wr_port #(.RST_VAL(`SCCC_RST_CLAMP)) u_clamp (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(clamp_wr),
    .wr_data({reg_wdata[7:1], 1'b0}),
    .q_r(clamp_coast_control)
  );
  sccc_wr_port #(.RST_VAL(`SCCC_RST_PRE)) u_pre (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(pre_wr),
    .wr_data(reg_wdata),
    .q_r(pre_coast_lines)
  );
  sccc_wr_port #(.RST_VAL(`SCCC_RST_POST)) u_post (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(post_wr),
    .wr_data(reg_wdata),
    .q_r(post_coast_lines)
  );
  // bit 0 here belongs to the 4:2:2 setting, stored but not decoded here
  sccc_wr_port #(.RST_VAL(`SCCC_RST_OUTP)) u_outp (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(outp_wr),
    .wr_data(reg_wdata),
    .q_r(output_power_control)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path
  ////////////////////////////////////////////////////////////////////////////

  reg [7:0] rdata_nxt;

  // unmapped offsets read zero; reads have no side effect
  always @* begin
    case (reg_addr)
      `SCCC_OFS_DIV_HI: rdata_nxt = div_hi_q;
      `SCCC_OFS_DIV_LO: rdata_nxt = div_lo_q;
      `SCCC_OFS_SYNC: rdata_nxt = sync_source_polarity_control;
      `SCCC_OFS_CLAMP: rdata_nxt = clamp_coast_control;
      `SCCC_OFS_PRE: rdata_nxt = pre_coast_lines;
      `SCCC_OFS_POST: rdata_nxt = post_coast_lines;
      `SCCC_OFS_OUTP: rdata_nxt = output_power_control;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data lands one cycle after the read strobe
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // divide ratio update
  ////////////////////////////////////////////////////////////////////////////

  // take the high byte staged earlier with the new low nibble, so the pll
  // never sees a half-updated ratio while the controller writes byte by byte
  always @(posedge sys_clk) begin
    if (rst) begin
      line_clock_divide_ratio_r <= {`SCCC_RST_DIV_HI, `SCCC_RST_DIV_LO};
    end else if (div_lo_wr) begin
      line_clock_divide_ratio_r <= {div_hi_q, reg_wdata[7:4]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync selection
  ////////////////////////////////////////////////////////////////////////////

  reg hsync_in_high_nxt;
  reg hsync_green_nxt;
  reg coast_in_high_nxt;

  // override bits pick between the setting and the detected/auto choice
  always @* begin
    if (sync_source_polarity_control[`SCCC_HPOL_OVR]) begin
      hsync_in_high_nxt = sync_source_polarity_control[`SCCC_HPOL_IN];
    end else begin
      hsync_in_high_nxt = hsync_pol_detected;
    end
    // with no override and a single sync, the pin is the default source
    if (sync_source_polarity_control[`SCCC_HSRC_OVR] || hsync_both_active) begin
      hsync_green_nxt = sync_source_polarity_control[`SCCC_HSRC_SEL];
    end else begin
      hsync_green_nxt = 1'b0;
    end
    if (clamp_coast_control[`SCCC_CPOL_OVR]) begin
      coast_in_high_nxt = clamp_coast_control[`SCCC_CPOL_IN];
    end else begin
      coast_in_high_nxt = coast_pol_detected;
    end
  end

  // hsync group; registered so every control output comes straight from a flop
  always @(posedge sys_clk) begin
    if (rst) begin
      hsync_in_high_r <= 1'b1;
      hsync_out_low_r <= 1'b0;
      hsync_from_green_channel_sync_r <= 1'b0;
    end else begin
      hsync_in_high_r <= hsync_in_high_nxt;
      hsync_out_low_r <= sync_source_polarity_control[`SCCC_HPOL_OUT];
      hsync_from_green_channel_sync_r <= hsync_green_nxt;
    end
  end

  // vsync group; source choice only honoured under override, else the pin
  always @(posedge sys_clk) begin
    if (rst) begin
      vsync_out_noninv_r <= 1'b0;
      vsync_src_force_r <= 1'b0;
      vsync_from_separator_r <= 1'b0;
    end else begin
      vsync_out_noninv_r <= sync_source_polarity_control[`SCCC_VPOL_OUT];
      vsync_src_force_r <= sync_source_polarity_control[`SCCC_VSRC_OVR];
      vsync_from_separator_r <= sync_source_polarity_control[`SCCC_VSRC_OVR] &
                                sync_source_polarity_control[`SCCC_VSRC_SEL];
    end
  end

  // coast polarity; reset leaves it high, while coast itself comes out of reset enabled
  always @(posedge sys_clk) begin
    if (rst) begin
      coast_in_high_r <= 1'b1;
    end else begin
      coast_in_high_r <= coast_in_high_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clamp, coast, output and power
  ////////////////////////////////////////////////////////////////////////////

  genvar ch;
  // red, green, blue clamp level bits share one pattern
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_clamp
      always @(posedge sys_clk) begin
        if (rst) begin
          clamp_midscale_r[ch] <= 1'b0;
        end else begin
          clamp_midscale_r[ch] <= clamp_coast_control[`SCCC_CLAMP_B + ch];
        end
      end
    end
  endgenerate

  // clamp and coast enables
  always @(posedge sys_clk) begin
    if (rst) begin
      clamp_enable_r <= 1'b1;
      coast_enable_r <= 1'b1;
    end else begin
      clamp_enable_r <= ~clamp_coast_control[`SCCC_CLAMP_OFF];
      coast_enable_r <= clamp_coast_control[`SCCC_COAST_EN];
    end
  end

  // coast line counts; plain copies, the sync block does the counting
  always @(posedge sys_clk) begin
    if (rst) begin
      pre_coast_lines_r <= `SCCC_RST_PRE;
      post_coast_lines_r <= `SCCC_RST_POST;
    end else begin
      pre_coast_lines_r <= pre_coast_lines;
      post_coast_lines_r <= post_coast_lines;
    end
  end

  // output drive, bandwidth and data clock polarity
  always @(posedge sys_clk) begin
    if (rst) begin
      drive_strength_r <= 2'h3;
      bandwidth_high_r <= 1'b1;
      data_clock_invert_r <= 1'b0;
    end else begin
      drive_strength_r <= output_power_control[`SCCC_DRIVE_HI:`SCCC_DRIVE_LO];
      bandwidth_high_r <= output_power_control[`SCCC_BW_HIGH];
      data_clock_invert_r <= output_power_control[`SCCC_CLK_INV];
    end
  end

  // pixel output hiz only obeyed in digital mode; analog keeps driving
  always @(posedge sys_clk) begin
    if (rst) begin
      pixel_data_outputs_hiz_r <= 1'b0;
    end else begin
      pixel_data_outputs_hiz_r <= output_power_control[`SCCC_PDO_HIZ] &
                                  digital_mode;
    end
  end

  // hdcp address bit and power-down; power-down is the inverse of the run bit
  always @(posedge sys_clk) begin
    if (rst) begin
      hdcp_addr_bit_r <= 1'b0;
      power_down_r <= 1'b0;
    end else begin
      hdcp_addr_bit_r <= output_power_control[`SCCC_HDCP_ADR];
      power_down_r <= ~output_power_control[`SCCC_RUN];
    end
  end

endmodule // sccc_regs
`default_nettype wire

// ===== sim/sccc_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module sccc_regs_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid_r,
  input wire logic digital_mode,
  input wire logic [11:0] line_clock_divide_ratio_r,
  input wire logic [7:0] pre_coast_lines_r,
  input wire logic clamp_enable_r,
  input wire logic pixel_data_outputs_hiz_r,
  input wire logic power_down_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // answer timing of the byte port
  AST_RD_ANS: assert property (reg_rd |=> reg_rvalid_r) else $error("read not answered");
  AST_RD_ONE: assert property (!reg_rd |=> !reg_rvalid_r) else $error("stray read valid");
  // divider moves only on a low-byte write, and then takes its nibble
  AST_DIV_KEEP: assert property (!(reg_wr && reg_addr == 8'h02) |=>
    $stable(line_clock_divide_ratio_r)) else $error("divider moved");
  AST_DIV_LOAD: assert property ((reg_wr && reg_addr == 8'h02) |=>
    line_clock_divide_ratio_r[3:0] == $past(reg_wdata[7:4])) else $error("divider nibble");
  // derived outputs follow two edges after the write
  AST_PRE: assert property ((reg_wr && reg_addr == 8'h12) |-> ##2
    pre_coast_lines_r == $past(reg_wdata, 2)) else $error("pre-coast count");
  AST_CLAMP: assert property ((reg_wr && reg_addr == 8'h11) |-> ##2
    clamp_enable_r == !$past(reg_wdata[7], 2)) else $error("clamp enable");
  AST_PWR: assert property ((reg_wr && reg_addr == 8'h14) |-> ##2
    power_down_r == !$past(reg_wdata[1], 2)) else $error("power down");
  // tri-state of pixel outputs only in digital mode
  AST_HIZ: assert property (pixel_data_outputs_hiz_r |-> $past(digital_mode))
    else $error("hiz outside digital mode");
endmodule // sccc_regs_props
bind sccc_regs sccc_regs_props chk_u (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rvalid_r, .digital_mode, .line_clock_divide_ratio_r,
  .pre_coast_lines_r, .clamp_enable_r, .pixel_data_outputs_hiz_r, .power_down_r);
`default_nettype wire

// ===== sim/sccc_ctl_model.sv
`timescale 1ns/100ps
`default_nettype none
module sccc_ctl_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // quiet bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one byte access per cycle, raised at the falling edge, taken at the rising one
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
  endtask
  // released lines show the inverse so a stale byte never passes for data
  task automatic idle(input int n);
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    repeat (n) @(negedge sys_clk);
  endtask
endmodule // sccc_ctl_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, rst, hsync_pol_detected, coast_pol_detected, hsync_both_active, digital_mode;
  wire reg_wr, reg_rd, reg_rvalid_r, hsync_in_high_r, hsync_out_low_r, vsync_out_noninv_r;
  wire hsync_from_green_channel_sync_r, vsync_src_force_r, vsync_from_separator_r;
  wire clamp_enable_r, coast_enable_r, coast_in_high_r, bandwidth_high_r, data_clock_invert_r;
  wire pixel_data_outputs_hiz_r, hdcp_addr_bit_r, power_down_r;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_r, pre_coast_lines_r, post_coast_lines_r;
  wire [11:0] line_clock_divide_ratio_r;
  wire [2:0] clamp_midscale_r;
  wire [1:0] drive_strength_r;
  integer n_errors = 0, tests_run = 0, seed = 32'hbcd2;
  logic [7:0] exp_q[$];
  logic [7:0] v, hi, w;
  logic [7:0] ofs [8] = '{8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic [7:0] rv [8] = '{8'h69, 8'hd0, 8'h40, 8'h0a, 8'h00, 8'h00, 8'he2, 8'h00};
  sccc_regs dut_u (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r,
    .reg_rvalid_r, .hsync_pol_detected, .coast_pol_detected, .hsync_both_active, .digital_mode,
    .line_clock_divide_ratio_r, .hsync_in_high_r, .hsync_out_low_r,
    .hsync_from_green_channel_sync_r, .vsync_out_noninv_r, .vsync_src_force_r,
    .vsync_from_separator_r, .clamp_enable_r, .clamp_midscale_r, .coast_enable_r,
    .coast_in_high_r, .pre_coast_lines_r, .post_coast_lines_r, .drive_strength_r,
    .bandwidth_high_r, .data_clock_invert_r, .pixel_data_outputs_hiz_r, .hdcp_addr_bit_r,
    .power_down_r);
  sccc_ctl_model ctl_u (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // the expected byte is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ctl_u.xfer(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctl_u.xfer(1'b1, 1'b0, a, d);
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a watchdog well past the expected run
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    n_errors++;
    test_done;
  end
  // read monitor: the oldest note is due whenever valid shows
  always @(negedge sys_clk) begin
    if (reg_rvalid_r === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected read", 16'h0000, 16'h0001);
      else cmp("read data", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_r});
    end
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {hsync_pol_detected, coast_pol_detected, hsync_both_active, digital_mode} = 4'h0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    ctl_u.idle(1);
    cmp("divider reset", 16'h069d, {4'h0, line_clock_divide_ratio_r});
    hi = 8'($random(seed));
    v = 8'($random(seed));
    wr(8'h20, 8'hff);
    wr(8'h01, hi);
    rd(8'h20, 8'h00);
    ctl_u.idle(1);
    cmp("divider held", 16'h069d, {4'h0, line_clock_divide_ratio_r});
    wr(8'h02, v);
    rd(8'h02, {v[7:4], 4'h0});
    ctl_u.idle(0);
    cmp("divider loaded", {4'h0, hi, v[7:4]}, {4'h0, line_clock_divide_ratio_r});
    // random settings under random status, controller at varying pace
    repeat (40) begin
      {hsync_pol_detected, coast_pol_detected, hsync_both_active, digital_mode} = 4'($random(seed));
      v = 8'($random(seed));
      hi = 8'($random(seed));
      w = 8'($random(seed));
      hi[1] = hi[1] | ~hi[3];
      wr(8'h10, v);
      wr(8'h11, hi);
      wr(8'h12, w ^ v);
      wr(8'h13, ~w);
      wr(8'h14, w);
      rd(8'h10, v);
      rd(8'h11, {hi[7:1], 1'b0});
      rd(8'h14, w);
      ctl_u.idle($unsigned($random(seed)) % 3);
      cmp("sync outputs", {10'h000, v[7] ? v[6] : hsync_pol_detected, v[5],
        (v[4] | hsync_both_active) & v[3], v[2], v[1], v[1] & v[0]}, {10'h000,
        hsync_in_high_r, hsync_out_low_r, hsync_from_green_channel_sync_r,
        vsync_out_noninv_r, vsync_src_force_r, vsync_from_separator_r});
      cmp("clamp coast", {10'h000, ~hi[7], hi[6:3],
        hi[2] ? hi[1] : coast_pol_detected}, {10'h000, clamp_enable_r, clamp_midscale_r,
        coast_enable_r, coast_in_high_r});
      cmp("coast lines", {w ^ v, ~w}, {pre_coast_lines_r, post_coast_lines_r});
      cmp("output power", {8'h00, w[7:4],
        w[3] & digital_mode, w[2], ~w[1], 1'b0}, {8'h00, drive_strength_r, bandwidth_high_r,
        data_clock_invert_r, pixel_data_outputs_hiz_r, hdcp_addr_bit_r, power_down_r, 1'b0});
    end
    ctl_u.idle(1);
    cmp("reads left", 16'h0000, 16'(exp_q.size()));
    test_done;
  end
endmodule // tb
`default_nettype wire
